// ===== rtl/etxd_bus_if.sv
/*
 * Host memory bus joining the DMA (master) and host memory (slave).
 * Assumes one clock; request held until a one-cycle ack.
 */
`default_nettype none
interface etxd_bus_if;
	logic req;
	logic we;
	logic [31:0] addr;
	logic [31:0] wdata;
	logic ack;
	logic [31:0] rdata;
	modport dma(output req, output we, output addr, output wdata, input ack, input rdata);
	modport mem(input req, input we, input addr, input wdata, output ack, output rdata);
endinterface
`default_nettype wire

// ===== rtl/etxd_dma.sv
/*
 * Descriptor DMA: transmit engine, receive buffer filler, byte FIFO toward the MAC.
 * Assumes host memory on etxd_bus_if and a transaction layer that returns one
 * status per frame, in frame order.
 */
// How it works
// - move exactly buffer-size bytes per buffer
// - tag first byte sof, last byte eof
// - fill buffer until full or eof
// - last rx descriptor reports frame length 29:16
// - unaligned rx start writes dummy leading bytes
// - host readies buffers before setting ownership
// - tx start bit puts engine in run
// - host-owned or error sets tbu and nis
// - owned descriptor fetched; intermediates closed
// - timestamp words 2,3 only if captured
// - tx interrupt only with completion bit
// - default suspend exits on poll, underflow clear
// - second-frame mode moves second frame before first status
// - prefetch while prior last still open
// - wait prior status, write stamp, close
// - underflow in prior status forces suspend
// - suspended engine still writes pending status
// - second-frame mode resumes only on poll
// - software keeps more than two descriptors
// - host supplies complete frames, check bytes
// - first/last flags bound frames; next not first
// - send at threshold, full frame, store-forward
`default_nettype none
module etxd_fifo #(
	parameter int W = 10,
	parameter int DEPTH = 32
)(
	input wire logic mclk_in,
	input wire logic rst_n_in,
	input wire logic wr_valid_in,
	output logic wr_ready_out,
	input wire logic [W-1:0] wr_data_in,
	output logic rd_valid_out,
	input wire logic rd_ready_in,
	output logic [W-1:0] rd_data_out,
	output logic [$clog2(DEPTH):0] count_out
);
	localparam int AW = $clog2(DEPTH);
	logic [W-1:0] mem [DEPTH];
	logic [AW:0] wp;
	logic [AW:0] rp;
	assign count_out = wp - rp;
	assign wr_ready_out = count_out != (AW+1)'(DEPTH);
	assign rd_valid_out = wp != rp;
	assign rd_data_out = mem[rp[AW-1:0]];
	always_ff @(posedge mclk_in)
	begin
		if (wr_valid_in && wr_ready_out)
			mem[wp[AW-1:0]] <= wr_data_in;
	end
	always_ff @(posedge mclk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			wp <= '0;
			rp <= '0;
		end
		else
		begin
			if (wr_valid_in && wr_ready_out)
				wp <= wp + 1'b1;
			if (rd_valid_out && rd_ready_in)
				rp <= rp + 1'b1;
		end
	end
endmodule // etxd_fifo

module etxd_dma
	import etxd_pkg::*;
#(
	parameter int FIFO_DEPTH = 32
)(
	input wire logic mclk_in,
	input wire logic rst_n_in,
	etxd_bus_if.dma bus,
	input wire logic [31:0] op_mode_in,
	input wire logic [31:0] tx_list_base_in,
	input wire logic [31:0] rx_list_base_in,
	input wire logic tx_poll_in,
	input wire logic rx_poll_in,
	input wire logic [31:0] status_clear_in,
	output logic [31:0] status_out,
	output logic mtl_valid_out,
	input wire logic mtl_ready_in,
	output logic [7:0] mtl_data_out,
	output logic mtl_sof_out,
	output logic mtl_eof_out,
	input wire logic tx_stat_valid_in,
	output logic tx_stat_ready_out,
	input wire logic [31:0] tx_stat_word_in,
	input wire logic [63:0] tx_stat_ts_in,
	input wire logic rx_valid_in,
	output logic rx_ready_out,
	input wire logic [7:0] rx_data_in,
	input wire logic rx_last_in
);
	localparam int CW = $clog2(FIFO_DEPTH) + 1;
	etxd_tx_st_t txs;
	etxd_rx_st_t rxs;
	logic [31:0] sts, cur, ctl, baddr, nxt, wbuf, pend_addr, close_addr, st_word;
	logic [63:0] ts;
	logic [10:0] rem;
	logic [1:0] lane;
	logic sof_p, in_frame, pending, pend_ioc, close_ioc, ret_susp;
	logic tx_req, tx_we, rx_req, rx_we, lock, lock_rx, pick_rx, tack, rack;
	logic [31:0] tx_addr, tx_wdata, rx_addr, rx_wdata, next_d, rnext_d;
	logic [31:0] rcur, rctl, rbuf, rnxt, rword;
	logic [11:0] rcnt;
	logic [13:0] rflen;
	logic [1:0] rlane;
	logic rfirst, reof, push, pop, f_ready, f_valid, tx_go, start_ok, take_stat;
	logic [FIFO_W-1:0] f_out;
	logic [CW-1:0] f_cnt, eof_cnt;
	logic [31:0] set_bits;
	wire logic tx_on = op_mode_in[OM_TX_START];
	wire logic second_frame_mode_bit = op_mode_in[OM_OSF];

	assign next_d = etxd_next_desc(cur, ctl, nxt, tx_list_base_in);
	assign rnext_d = etxd_next_desc(rcur, rctl, rnxt, rx_list_base_in);
	assign status_out = sts;

	// bus arbiter; grant held until the ack so a request is never split
	assign pick_rx = lock ? lock_rx : rx_req;
	assign bus.req = pick_rx ? rx_req : tx_req;
	assign bus.we = pick_rx ? rx_we : tx_we;
	assign bus.addr = pick_rx ? rx_addr : tx_addr;
	assign bus.wdata = pick_rx ? rx_wdata : tx_wdata;
	assign tack = bus.ack && !pick_rx;
	assign rack = bus.ack && pick_rx;
	always_ff @(posedge mclk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			lock <= 1'b0;
			lock_rx <= 1'b0;
		end
		else if (bus.ack)
			lock <= 1'b0;
		else if (bus.req && !lock)
		begin
			lock <= 1'b1;
			lock_rx <= pick_rx;
		end
	end

	always_comb
	begin
		tx_req = 1'b1;
		tx_we = 1'b0;
		tx_addr = cur + DESC_W0;
		tx_wdata = '0;
		case (txs)
			TS_F0: tx_addr = cur + DESC_W0;
			TS_F1: tx_addr = cur + DESC_W1;
			TS_F2: tx_addr = cur + DESC_W2;
			TS_F3: tx_addr = cur + DESC_W3;
			TS_RD: tx_addr = {baddr[31:2], 2'b00};
			TS_CLOSE: tx_we = 1'b1; // intermediate closed, ownership cleared
			TS_TSL:
			begin
				tx_we = 1'b1;
				tx_addr = close_addr + DESC_W2;
				tx_wdata = ts[31:0];
			end
			TS_TSH:
			begin
				tx_we = 1'b1;
				tx_addr = close_addr + DESC_W3;
				tx_wdata = ts[63:32];
			end
			TS_STAT:
			begin
				tx_we = 1'b1;
				tx_addr = close_addr + DESC_W0;
				tx_wdata = {1'b0, st_word[30:0]};
			end
			default: tx_req = 1'b0;
		endcase
	end

	assign push = (txs == TS_PUSH) && f_ready;
	assign take_stat = tx_stat_valid_in && (txs == TS_WAIT || (txs == TS_SUSP && pending));
	assign tx_stat_ready_out = take_stat;

	always_ff @(posedge mclk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			txs <= TS_STOP;
			cur <= '0;
			ctl <= '0;
			baddr <= '0;
			nxt <= '0;
			wbuf <= '0;
			rem <= '0;
			lane <= '0;
			sof_p <= 1'b0;
			in_frame <= 1'b0;
			pending <= 1'b0;
			pend_addr <= '0;
			pend_ioc <= 1'b0;
			ret_susp <= 1'b0;
		end
		else
		begin
			case (txs)
				TS_STOP:
					if (tx_on)
					begin
						cur <= tx_list_base_in;
						txs <= TS_F0;
					end
				TS_F0:
					if (tack)
						txs <= bus.rdata[OWN_BIT] ? TS_F1 : TS_SUSP;
				TS_F1:
					if (tack)
					begin
						ctl <= bus.rdata;
						// a start flag inside an open frame is an error
						txs <= (in_frame && bus.rdata[FSEG_BIT]) ? TS_SUSP : TS_F2;
					end
				TS_F2:
					if (tack)
					begin
						baddr <= bus.rdata;
						txs <= TS_F3;
					end
				TS_F3:
					if (tack)
					begin
						nxt <= bus.rdata;
						rem <= ctl[BSIZE_MSB:0];
						sof_p <= ctl[FSEG_BIT];
						in_frame <= !ctl[LSEG_BIT];
						if (ctl[BSIZE_MSB:0] != '0)
							txs <= TS_RD;
						else
							txs <= ctl[LSEG_BIT] ? TS_WAIT : TS_CLOSE;
					end
				TS_RD:
					if (tack)
					begin
						wbuf <= bus.rdata;
						lane <= baddr[1:0]; // leading lanes skipped
						baddr <= {baddr[31:2] + 30'h1, 2'b00};
						txs <= TS_PUSH;
					end
				TS_PUSH:
					if (push)
					begin
						rem <= rem - 11'h1;
						lane <= lane + 2'h1;
						sof_p <= 1'b0;
						if (rem == 11'h1)
						begin
							if (!ctl[LSEG_BIT])
								txs <= TS_CLOSE;
							else if (second_frame_mode_bit && !pending)
							begin
								pending <= 1'b1;
								pend_addr <= cur;
								pend_ioc <= ctl[IOC_BIT];
								cur <= next_d;
								txs <= TS_F0;
							end
							else
								txs <= TS_WAIT;
						end
						else if (lane == 2'h3)
							txs <= TS_RD;
					end
				TS_CLOSE:
					if (tack)
					begin
						cur <= next_d;
						txs <= TS_F0;
					end
				TS_WAIT:
					if (take_stat)
						txs <= tx_stat_word_in[STAT_TS_BIT] ? TS_TSL : TS_STAT;
				TS_TSL:
					if (tack)
						txs <= TS_TSH;
				TS_TSH:
					if (tack)
						txs <= TS_STAT;
				TS_STAT:
					if (tack)
					begin
						// underflow suspends; a write made while suspended returns there
						txs <= (ret_susp || st_word[STAT_UF_BIT]) ? TS_SUSP : TS_F0;
						ret_susp <= 1'b0;
						if (ret_susp)
							pending <= 1'b0;
						else
						begin
							cur <= next_d;
							pending <= second_frame_mode_bit;
							pend_addr <= cur;
							pend_ioc <= ctl[IOC_BIT];
						end
					end
				TS_SUSP:
					if (take_stat)
					begin
						ret_susp <= 1'b1;
						txs <= tx_stat_word_in[STAT_TS_BIT] ? TS_TSL : TS_STAT;
					end
					else if (tx_poll_in && (second_frame_mode_bit || !sts[ST_TU]))
						txs <= TS_F0;
					else if (!tx_on)
						txs <= TS_STOP;
				default: txs <= TS_STOP;
			endcase
		end
	end

	// latch the status of the frame being closed
	always_ff @(posedge mclk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			st_word <= '0;
			ts <= '0;
			close_addr <= '0;
			close_ioc <= 1'b0;
		end
		else if (take_stat)
		begin
			st_word <= tx_stat_word_in;
			ts <= tx_stat_ts_in;
			close_addr <= pending ? pend_addr : cur;
			close_ioc <= pending ? pend_ioc : ctl[IOC_BIT];
		end
	end

	etxd_fifo #(.W(FIFO_W), .DEPTH(FIFO_DEPTH)) u_fifo (
		.mclk_in(mclk_in),
		.rst_n_in(rst_n_in),
		.wr_valid_in(txs == TS_PUSH),
		.wr_ready_out(f_ready),
		.wr_data_in({ctl[LSEG_BIT] && rem == 11'h1, sof_p, wbuf[{lane, 3'b000} +: 8]}),
		.rd_valid_out(f_valid),
		.rd_ready_in(mtl_ready_in && mtl_valid_out),
		.rd_data_out(f_out),
		.count_out(f_cnt)
	);

	// frames leave only at the threshold with OM_SF clear, once whole or with the FIFO full; a started frame runs on
	assign start_ok = eof_cnt != '0 || f_cnt == CW'(FIFO_DEPTH)
		|| (!op_mode_in[OM_SF]
		&& f_cnt >= CW'(etxd_thr_bytes(op_mode_in[OM_THR_MSB:OM_THR_LSB])));
	assign mtl_valid_out = f_valid && (tx_go || start_ok);
	assign pop = mtl_valid_out && mtl_ready_in;
	assign mtl_data_out = f_out[7:0];
	assign mtl_sof_out = f_out[E_SOF];
	assign mtl_eof_out = f_out[E_EOF];
	always_ff @(posedge mclk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			eof_cnt <= '0;
			tx_go <= 1'b0;
		end
		else
		begin
			eof_cnt <= eof_cnt + CW'(push && txs == TS_PUSH && ctl[LSEG_BIT] && rem == 11'h1)
				- CW'(pop && f_out[E_EOF]);
			if (pop)
				tx_go <= !f_out[E_EOF];
		end
	end

	always_comb
	begin
		rx_req = 1'b1;
		rx_we = 1'b0;
		rx_addr = rcur + DESC_W0;
		rx_wdata = '0;
		case (rxs)
			RS_F0: rx_addr = rcur + DESC_W0;
			RS_F1: rx_addr = rcur + DESC_W1;
			RS_F2: rx_addr = rcur + DESC_W2;
			RS_F3: rx_addr = rcur + DESC_W3;
			RS_WR:
			begin
				rx_we = 1'b1;
				rx_addr = {rbuf[31:2], 2'b00};
				rx_wdata = rword; // lanes below the start stay dummy
			end
			RS_CLOSE:
			begin
				rx_we = 1'b1;
				rx_wdata[RX_FL_MSB:RX_FL_LSB] = reof ? rflen : 14'h0;
				rx_wdata[RX_FS_BIT] = rfirst;
				rx_wdata[RX_LS_BIT] = reof;
			end
			default: rx_req = 1'b0;
		endcase
	end

	assign rx_ready_out = rxs == RS_FILL;
	always_ff @(posedge mclk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			rxs <= RS_STOP;
			rcur <= '0;
			rctl <= '0;
			rbuf <= '0;
			rnxt <= '0;
			rword <= '0;
			rcnt <= '0;
			rflen <= '0;
			rlane <= '0;
			rfirst <= 1'b1;
			reof <= 1'b0;
		end
		else
		begin
			case (rxs)
				RS_STOP:
					if (op_mode_in[OM_RX_START])
					begin
						rcur <= rx_list_base_in;
						rfirst <= 1'b1;
						rxs <= RS_F0;
					end
				RS_F0:
					if (rack)
						rxs <= bus.rdata[OWN_BIT] ? RS_F1 : RS_SUSP;
				RS_F1:
					if (rack)
					begin
						rctl <= bus.rdata;
						rxs <= RS_F2;
					end
				RS_F2:
					if (rack)
					begin
						rbuf <= bus.rdata;
						rlane <= bus.rdata[1:0];
						rcnt <= {10'h000, bus.rdata[1:0]}; // offset eats buffer space
						rword <= '0;
						rxs <= RS_F3;
					end
				RS_F3:
					if (rack)
					begin
						rnxt <= bus.rdata;
						rxs <= RS_FILL;
					end
				RS_FILL:
					if (rx_valid_in)
					begin
						rword[{rlane, 3'b000} +: 8] <= rx_data_in;
						rcnt <= rcnt + 12'h1;
						rflen <= rflen + 14'h1;
						rlane <= rlane + 2'h1;
						reof <= rx_last_in;
						if (rx_last_in || rlane == 2'h3
							|| rcnt + 12'h1 == {1'b0, rctl[BSIZE_MSB:0]})
							rxs <= RS_WR;
					end
				RS_WR:
					if (rack)
					begin
						rbuf <= {rbuf[31:2] + 30'h1, 2'b00};
						rword <= '0;
						rlane <= 2'h0;
						rxs <= (reof || rcnt == {1'b0, rctl[BSIZE_MSB:0]}) ? RS_CLOSE : RS_FILL;
					end
				RS_CLOSE:
					if (rack)
					begin
						// a closed frame means the next frame opens a fresh descriptor
						rfirst <= reof;
						if (reof)
							rflen <= '0;
						reof <= 1'b0;
						rcur <= rnext_d;
						rxs <= RS_F0;
					end
				RS_SUSP:
					if (rx_poll_in || rx_valid_in)
						rxs <= RS_F0;
					else if (!op_mode_in[OM_RX_START])
						rxs <= RS_STOP;
				default: rxs <= RS_STOP;
			endcase
		end
	end

	always_comb
	begin
		set_bits = '0;
		set_bits[ST_TBU] = (txs == TS_F0 && tack && !bus.rdata[OWN_BIT])
			|| (txs == TS_F1 && tack && in_frame && bus.rdata[FSEG_BIT]);
		set_bits[ST_TI] = txs == TS_STAT && tack && close_ioc;
		set_bits[ST_TU] = txs == TS_STAT && tack && st_word[STAT_UF_BIT];
		set_bits[ST_RI] = rxs == RS_CLOSE && rack && reof;
		set_bits[ST_RU] = rxs == RS_F0 && rack && !bus.rdata[OWN_BIT];
		set_bits[ST_AIS] = set_bits[ST_TU] || set_bits[ST_RU];
		set_bits[ST_NIS] = set_bits[ST_TBU] || set_bits[ST_TI] || set_bits[ST_RI];
	end
	// a set arriving with its clear wins
	always_ff @(posedge mclk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			sts <= STATUS_RESET;
		else
			sts <= (sts & ~status_clear_in) | set_bits;
	end
endmodule // etxd_dma
`default_nettype wire

// ===== rtl/etxd_host.sv
/*
 * Host memory end: word memory served over etxd_bus_if plus a driver port.
 * Assumes the driver builds descriptor lists and frames through drv_* writes.
 */
`default_nettype none
module etxd_host
	import etxd_pkg::*;
#(
	parameter int MEM_AW = 10
)(
	input wire logic mclk_in,
	input wire logic rst_n_in,
	etxd_bus_if.mem bus,
	input wire logic drv_we_in,
	input wire logic [31:0] drv_addr_in,
	input wire logic [31:0] drv_wdata_in,
	output logic [31:0] drv_rdata_out
);
	logic [31:0] mem [2**MEM_AW];
	logic ack;
	logic [31:0] rdata;
	wire logic take = bus.req && !ack;
	assign bus.ack = ack;
	assign bus.rdata = rdata;

	// driver write lands last so it wins a same-word clash
	always_ff @(posedge mclk_in)
	begin
		if (take && bus.we)
			mem[bus.addr[MEM_AW+1:2]] <= bus.wdata;
		// words land in write order: ownership word written last
		if (drv_we_in)
			mem[drv_addr_in[MEM_AW+1:2]] <= drv_wdata_in;
	end

	always_ff @(posedge mclk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			ack <= 1'b0;
			rdata <= '0;
			drv_rdata_out <= '0;
		end
		else
		begin
			ack <= take;
			if (take)
				rdata <= mem[bus.addr[MEM_AW+1:2]];
			drv_rdata_out <= mem[drv_addr_in[MEM_AW+1:2]];
		end
	end
endmodule // etxd_host
`default_nettype wire

// ===== rtl/etxd_pkg.sv
/*
 * Shared constants for the transmit/receive descriptor DMA and its host memory.
 * Assumes 32-bit word-addressed host memory and byte-wide MAC-side streams.
 */
`default_nettype none
package etxd_pkg;
	localparam logic [31:0] DESC_W0 = 32'h0;
	localparam logic [31:0] DESC_W1 = 32'h4;
	localparam logic [31:0] DESC_W2 = 32'h8;
	localparam logic [31:0] DESC_W3 = 32'hC;
	localparam logic [31:0] DESC_STRIDE = 32'h10;
	// descriptor bit positions
	localparam int OWN_BIT = 31;
	localparam int IOC_BIT = 31;
	localparam int LSEG_BIT = 30;
	localparam int FSEG_BIT = 29;
	localparam int RING_END_BIT = 25;
	localparam int CHAIN_BIT = 24;
	localparam int BSIZE_MSB = 10;
	localparam int RX_FL_LSB = 16;
	localparam int RX_FL_MSB = 29;
	localparam int RX_FS_BIT = 9;
	localparam int RX_LS_BIT = 8;
	// status word from the transaction layer
	localparam int STAT_UF_BIT = 1;
	localparam int STAT_TS_BIT = 17;
	// operation mode word
	localparam int OM_RX_START = 1;
	localparam int OM_OSF = 2;
	localparam int OM_TX_START = 13;
	localparam int OM_THR_LSB = 14;
	localparam int OM_THR_MSB = 16;
	localparam int OM_SF = 21;
	// status word
	localparam int ST_TI = 0;
	localparam int ST_TBU = 2;
	localparam int ST_TU = 5;
	localparam int ST_RI = 6;
	localparam int ST_RU = 7;
	localparam int ST_AIS = 15;
	localparam int ST_NIS = 16;
	localparam logic [31:0] STATUS_RESET = 32'h0;
	// fifo entry: byte, start tag, end tag
	localparam int FIFO_W = 10;
	localparam int E_SOF = 8;
	localparam int E_EOF = 9;
	localparam logic [7:0] THR_STEP = 8'h04;

	typedef enum logic [12:0] {
		TS_STOP = 13'h0001, TS_F0 = 13'h0002, TS_F1 = 13'h0004, TS_F2 = 13'h0008,
		TS_F3 = 13'h0010, TS_RD = 13'h0020, TS_PUSH = 13'h0040, TS_CLOSE = 13'h0080,
		TS_WAIT = 13'h0100, TS_TSL = 13'h0200, TS_TSH = 13'h0400, TS_STAT = 13'h0800,
		TS_SUSP = 13'h1000
	} etxd_tx_st_t;

	typedef enum logic [8:0] {
		RS_STOP = 9'h001, RS_F0 = 9'h002, RS_F1 = 9'h004, RS_F2 = 9'h008,
		RS_F3 = 9'h010, RS_FILL = 9'h020, RS_WR = 9'h040, RS_CLOSE = 9'h080,
		RS_SUSP = 9'h100
	} etxd_rx_st_t;

	function automatic logic [31:0] etxd_next_desc(input logic [31:0] cur,
		input logic [31:0] ctl, input logic [31:0] nxt, input logic [31:0] base);
		if (ctl[CHAIN_BIT])
			return nxt;
		if (ctl[RING_END_BIT])
			return base;
		return cur + DESC_STRIDE;
	endfunction

	function automatic logic [7:0] etxd_thr_bytes(input logic [2:0] code);
		return 8'({5'h00, code} * THR_STEP) + THR_STEP;
	endfunction
endpackage
`default_nettype wire

// ===== verification/etxd_asserts.sv
/*
 * Checker on the host memory bus between the DMA and host memory.
 * Assumes one clock, async active-low reset, tx descriptors in [TX_LO, TX_HI].
 */
`default_nettype none
module etxd_asserts #(
	parameter logic [31:0] TX_LO = 32'h100,
	parameter logic [31:0] TX_HI = 32'h1FF
)(
	input wire logic mclk_in,
	input wire logic rst_n_in,
	input wire logic req_in,
	input wire logic we_in,
	input wire logic [31:0] addr_in,
	input wire logic [31:0] wdata_in,
	input wire logic ack_in,
	input wire logic [31:0] rdata_in
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge mclk_in);
	endclocking
	default disable iff (!rst_n_in);
	logic tx_wr;
	assign tx_wr = req_in && we_in && addr_in >= TX_LO && addr_in <= TX_HI;
	sequence s_taken;
		req_in && !ack_in;
	endsequence
	sequence s_answer;
		ack_in ##1 !ack_in;
	endsequence
	chk_ack_latency: assert property (s_taken |=> s_answer)
		else $error("bus answer not one cycle after request");
	chk_req_held: assert property (s_taken |=> req_in && $stable(addr_in) && $stable(we_in))
		else $error("request dropped or changed before answer");
	chk_wdata_held: assert property (s_taken ##0 we_in |=> $stable(wdata_in))
		else $error("write data changed before answer");
	chk_ack_cause: assert property (ack_in |-> $past(req_in) && !$past(ack_in))
		else $error("answer without a pending request");
	chk_write_aligned: assert property (req_in && we_in |-> addr_in[1:0] == 2'h0)
		else $error("unaligned write");
	chk_read_aligned: assert property (req_in && !we_in |-> addr_in[1:0] == 2'h0)
		else $error("unaligned read");
	chk_close_own: assert property (tx_wr && addr_in[3:0] == 4'h0 |-> !wdata_in[31])
		else $error("descriptor closed with owner still set");
	chk_ctl_untouched: assert property (tx_wr |-> addr_in[3:0] != 4'h4)
		else $error("descriptor control word written");
endmodule // etxd_asserts
`default_nettype wire

// ===== verification/tb.sv
/*
 * Self-checking bench: DMA and host memory joined by etxd_bus_if.
 * Assumes the host memory starts unwritten and a 50 MHz clock.
 */
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin fails++; \
	$display("ERROR %0t: got %h exp %h", $time, (a), (b)); end end
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import etxd_pkg::*;
	logic mclk_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic [31:0] op_mode = 32'h0;
	logic tx_poll = 1'b0;
	logic [31:0] st_clr = 32'h0;
	logic mtl_ready = 1'b1;
	logic stat_valid = 1'b0;
	logic [31:0] stat_word = 32'h0;
	logic [63:0] stat_ts = 64'h0;
	logic rx_valid = 1'b0;
	logic [7:0] rx_data = 8'h0;
	logic rx_last = 1'b0;
	logic drv_we = 1'b0;
	logic [31:0] drv_addr = 32'h0;
	logic [31:0] drv_wdata = 32'h0;
	logic [31:0] drv_rdata, status;
	logic mtl_valid, stat_ready, rx_ready, mtl_sof, mtl_eof;
	logic [7:0] mtl_data;
	logic [9:0] q[$];
	int fails = 0;
	int n_checks = 0;
	int cyc = 0;
	etxd_bus_if bus();
	etxd_dma #(.FIFO_DEPTH(32)) etxd_dma_inst (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
		.bus(bus), .op_mode_in(op_mode), .tx_list_base_in(32'h100),
		.rx_list_base_in(32'h300), .tx_poll_in(tx_poll), .rx_poll_in(1'b0),
		.status_clear_in(st_clr), .status_out(status), .mtl_valid_out(mtl_valid),
		.mtl_ready_in(mtl_ready), .mtl_data_out(mtl_data), .mtl_sof_out(mtl_sof),
		.mtl_eof_out(mtl_eof), .tx_stat_valid_in(stat_valid), .tx_stat_ready_out(stat_ready),
		.tx_stat_word_in(stat_word), .tx_stat_ts_in(stat_ts), .rx_valid_in(rx_valid),
		.rx_ready_out(rx_ready), .rx_data_in(rx_data), .rx_last_in(rx_last));
	etxd_host #(.MEM_AW(10)) etxd_host_inst (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
		.bus(bus), .drv_we_in(drv_we), .drv_addr_in(drv_addr), .drv_wdata_in(drv_wdata),
		.drv_rdata_out(drv_rdata));
	etxd_asserts etxd_asserts_inst (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
		.req_in(bus.req), .we_in(bus.we), .addr_in(bus.addr), .wdata_in(bus.wdata),
		.ack_in(bus.ack), .rdata_in(bus.rdata));
	initial
		forever #10 mclk_in = ~mclk_in;
	always @(posedge mclk_in)
		if (mtl_valid && mtl_ready)
			q.push_back({mtl_eof, mtl_sof, mtl_data});
	task automatic stop_test();
		if (fails == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// whole run needs well under this many cycles
	always @(posedge mclk_in)
	begin
		cyc++;
		if (cyc == 30000)
		begin
			fails++;
			$display("ERROR %0t: timeout", $time);
			stop_test();
		end
	end
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		@(posedge mclk_in);
		drv_we <= 1'b1;
		drv_addr <= a;
		drv_wdata <= d;
		@(posedge mclk_in);
		drv_we <= 1'b0;
	endtask
	task automatic rd(input logic [31:0] a, input logic [31:0] exp);
		@(posedge mclk_in);
		drv_addr <= a;
		@(posedge mclk_in);
		#1;
		`CHK(drv_rdata, exp)
	endtask
	task automatic desc(input logic [31:0] a, input logic [31:0] ctl, input logic [31:0] b);
		wr(a + 32'h4, ctl);
		wr(a + 32'h8, b);
		wr(a + 32'hC, 32'h0);
		wr(a, 32'h8000_0000); // owner handed over last
	endtask
	task automatic wait_bytes(input int n);
		for (int i = 0; i < 2000 && q.size() < n; i++)
			@(posedge mclk_in);
	endtask
	task automatic wait_bit(input int b);
		for (int i = 0; i < 2000 && status[b] !== 1'b1; i++)
			@(posedge mclk_in);
	endtask
	task automatic chk_byte(input logic [9:0] exp);
		logic [9:0] g;
		g = (q.size() > 0) ? q.pop_front() : 10'h3FF;
		`CHK(g, exp)
	endtask
	task automatic poll();
		@(posedge mclk_in);
		tx_poll <= 1'b1;
		@(posedge mclk_in);
		tx_poll <= 1'b0;
	endtask
	task automatic send_stat(input logic [31:0] w, input logic [63:0] ts);
		@(posedge mclk_in);
		stat_valid <= 1'b1;
		stat_word <= w;
		stat_ts <= ts;
		for (int i = 0; i < 2000; i++)
		begin
			@(posedge mclk_in);
			if (stat_ready === 1'b1)
				break;
		end
		stat_valid <= 1'b0;
	endtask
	// called right after an edge so a held strobe never repeats a byte
	task automatic rx_byte(input logic [7:0] d, input logic l);
		rx_valid <= 1'b1;
		rx_data <= d;
		rx_last <= l;
		for (int i = 0; i < 2000; i++)
		begin
			@(posedge mclk_in);
			if (rx_ready === 1'b1)
				break;
		end
	endtask
	task automatic t_rx();
		wr(32'h310, 32'h0);
		desc(32'h300, 32'h0000_0008, 32'h382);
		@(posedge mclk_in);
		op_mode <= 32'h0000_0002;
		@(posedge mclk_in);
		for (int k = 0; k < 6; k++)
			rx_byte(8'h41 + 8'(k), k == 5);
		rx_valid <= 1'b0;
		wait_bit(ST_RI);
		rd(32'h380, 32'h4241_0000);
		rd(32'h384, 32'h4645_4443);
		rd(32'h300, 32'h0006_0300);
	endtask
	task automatic t_tx();
		logic [9:0] fb[5] = '{10'h121, 10'h022, 10'h023, 10'h031, 10'h232};
		wr(32'h130, 32'h0);
		wr(32'h200, 32'h1211_AAAA);
		wr(32'h204, 32'hBB15_1413);
		wr(32'h210, 32'hCC23_2221);
		wr(32'h214, 32'hDDDD_3231);
		desc(32'h100, 32'hE000_0005, 32'h202);
		desc(32'h110, 32'h2000_0003, 32'h210);
		wr(32'h120, 32'h0);
		@(posedge mclk_in);
		mtl_ready <= 1'b0;
		op_mode <= 32'h0000_2000;
		repeat (40) @(posedge mclk_in);
		mtl_ready <= 1'b1;
		wait_bytes(5);
		for (int k = 0; k < 5; k++)
			chk_byte({k == 4, k == 0, 8'h11 + 8'(k)});
		send_stat(32'h0002_0000, 64'h0123_4567_89AB_CDEF);
		wait_bit(ST_TI);
		rd(32'h108, 32'h89AB_CDEF);
		rd(32'h10C, 32'h0123_4567);
		rd(32'h100, 32'h0002_0000);
		`CHK(status[ST_TI], 1'b1)
		wait_bit(ST_TBU);
		repeat (10) @(posedge mclk_in);
		`CHK(q.size(), 0)
		desc(32'h120, 32'h4000_0002, 32'h214);
		@(posedge mclk_in);
		st_clr <= 32'h0001_0005;
		@(posedge mclk_in);
		st_clr <= 32'h0;
		poll();
		wait_bytes(5);
		for (int k = 0; k < 5; k++)
			chk_byte(fb[k]);
		rd(32'h110, 32'h0);
		send_stat(32'h0000_0004, 64'hFFFF_FFFF_FFFF_FFFF);
		wait_bit(ST_TBU);
		rd(32'h120, 32'h0000_0004);
		rd(32'h128, 32'h0000_0214);
		`CHK(status[ST_TI], 1'b0)
		`CHK({status[ST_NIS], status[ST_TBU]}, 2'b11)
		`CHK(q.size(), 0)
		wr(32'h140, 32'h0);
		desc(32'h130, 32'hE000_0001, 32'h203);
		repeat (20) @(posedge mclk_in);
		`CHK(q.size(), 0)
		poll();
		wait_bytes(1);
		chk_byte(10'h312);
		// underflow in default mode: poll ignored until the flag is cleared
		send_stat(32'h0000_0002, 64'h0);
		wait_bit(ST_TU);
		rd(32'h130, 32'h0000_0002);
		desc(32'h140, 32'hE000_0001, 32'h205);
		poll();
		repeat (20) @(posedge mclk_in);
		`CHK(q.size(), 0)
		@(posedge mclk_in);
		st_clr <= 32'h0000_0020;
		@(posedge mclk_in);
		st_clr <= 32'h0;
		poll();
		wait_bytes(1);
		chk_byte(10'h314);
	endtask
	task automatic t_osf();
		@(posedge mclk_in);
		rst_n_in <= 1'b0;
		op_mode <= 32'h0;
		repeat (8) @(posedge mclk_in);
		rst_n_in <= 1'b1;
		q.delete();
		wr(32'h120, 32'h0);
		desc(32'h100, 32'h6000_0001, 32'h202);
		desc(32'h110, 32'h6000_0001, 32'h203);
		@(posedge mclk_in);
		op_mode <= 32'h0000_2004;
		wait_bytes(2);
		chk_byte(10'h311);
		chk_byte(10'h312);
		rd(32'h100, 32'h8000_0000);
		send_stat(32'h0000_0002, 64'h0);
		wait_bit(ST_TU);
		`CHK({status[ST_AIS], status[ST_TU]}, 2'b11)
		rd(32'h100, 32'h0000_0002);
		send_stat(32'h0002_0000, 64'h1111_2222_3333_4444);
		repeat (20) @(posedge mclk_in);
		rd(32'h110, 32'h0002_0000);
		rd(32'h118, 32'h3333_4444);
		wr(32'h130, 32'h0);
		desc(32'h120, 32'h6000_0001, 32'h204);
		repeat (20) @(posedge mclk_in);
		`CHK(q.size(), 0)
		poll();
		wait_bytes(1);
		chk_byte(10'h313);
	endtask
	initial
	begin
		repeat (8) @(posedge mclk_in);
		rst_n_in <= 1'b1;
		t_rx();
		t_tx();
		t_osf();
		stop_test();
	end
endmodule // tb
`default_nettype wire
